// ---- rtl/csat_top.sv ----
// module: card slot access timing engine with its axi4-lite register slave
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module csat_top
#(
  parameter int ADDR_W = 26
)
(
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CLK_EN,
  // axi4-lite write address and data
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // access requests
  input wire logic ACC_REQ,
  input wire logic ACC_WRITE,
  input wire logic [ADDR_W-1:0] ACC_ADDR,
  output logic ACC_BUSY,
  output logic ACC_DONE,
  // card side
  output logic [ADDR_W-1:0] CARD_ADDR,
  output logic CARD_ADDR_OE,
  output logic CARD_RD_N,
  output logic CARD_WE_N,
  output logic CARD_IO_SEL,
  input wire logic CARD_WAIT_N
);

  // ********************************************************************
  // parameter check
  // ********************************************************************
  if (ADDR_W < 2 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W must be 2 to 32");
  end

  // ********************************************************************
  // register slave
  // ********************************************************************
  logic [31:0] cfg_r, cfg_nxt;
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic busy_r, extw_r;

  always_comb
  begin
    logic [31:0] merged;
    merged = cfg_r;
    cfg_nxt = cfg_r;
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (S_AXI_AWVALID && awready_r)
    begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wready_r)
    begin
      w_full_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA;
      w_strb_nxt = S_AXI_WSTRB;
    end
    if (bvalid_r && S_AXI_BREADY)
      bvalid_nxt = 1'b0;
    if (aw_full_r && w_full_r && !bvalid_r)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = csat_pkg::RESP_SLVERR;
      if (aw_addr_r[11:2] == csat_pkg::CFG_ADDR[11:2])
      begin
        for (int b = 0; b < 4; b++)
          if (w_strb_r[b])
            merged[8*b +: 8] = w_data_r[8*b +: 8];
        cfg_nxt = merged & csat_pkg::CFG_WMASK; // [RULE_05]
        bresp_nxt = csat_pkg::RESP_OKAY;
      end
      else if (aw_addr_r[11:2] == csat_pkg::STAT_ADDR[11:2])
        bresp_nxt = csat_pkg::RESP_OKAY;
    end
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
    if (rvalid_r && S_AXI_RREADY)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (S_AXI_ARVALID && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = csat_pkg::RESP_OKAY;
      if (S_AXI_ARADDR[11:2] == csat_pkg::CFG_ADDR[11:2])
        rdata_nxt = cfg_r & csat_pkg::CFG_WMASK; // [RULE_05]
      else if (S_AXI_ARADDR[11:2] == csat_pkg::STAT_ADDR[11:2])
      begin
        rdata_nxt[csat_pkg::STAT_BUSY_BIT] = busy_r;
        rdata_nxt[csat_pkg::STAT_EXTW_BIT] = extw_r;
      end
      else
        rresp_nxt = csat_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      cfg_r <= csat_pkg::CFG_RESET; // [RULE_02]
      aw_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end
    else if (CLK_EN)
    begin
      cfg_r <= cfg_nxt;
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r <= w_full_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ********************************************************************
  // access sequencer
  // ********************************************************************
  csat_pkg::csat_cfg_t cfg, lat_r, lat_nxt;
  csat_pkg::csat_state_t st_r, st_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic oe_r, oe_nxt, rd_n_r, rd_n_nxt, we_n_r, we_n_nxt, io_r, io_nxt;
  logic wr_r, wr_nxt, busy_nxt, done_r, done_nxt, extw_nxt;

  assign cfg = csat_pkg::cfg_fields(cfg_r);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    lat_nxt = lat_r;
    addr_nxt = addr_r;
    oe_nxt = oe_r;
    rd_n_nxt = rd_n_r;
    we_n_nxt = we_n_r;
    io_nxt = io_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    extw_nxt = 1'b0;
    unique case (st_r)
      csat_pkg::CSAT_IDLE:
        if (ACC_REQ)
        begin
          lat_nxt = cfg;
          addr_nxt = ACC_ADDR;
          wr_nxt = ACC_WRITE;
          oe_nxt = 1'b1;
          io_nxt = ACC_ADDR[ADDR_W-1] ? cfg.upper_half_space_attr
                                      : cfg.lower_half_space_attr; // [RULE_08]
          cnt_nxt = {3'h0, csat_pkg::delay_code(cfg.addr_strobe_delay)}; // [RULE_07]
          st_nxt = csat_pkg::CSAT_SETUP;
        end
      csat_pkg::CSAT_SETUP:
        if (cnt_r == 7'h00)
        begin
          rd_n_nxt = wr_r;
          we_n_nxt = !wr_r;
          cnt_nxt = csat_pkg::wait_cycles(lat_r.access_wait_count) - 7'h01; // [RULE_01]
          st_nxt = csat_pkg::CSAT_STROBE;
        end
        else
          cnt_nxt = cnt_r - 7'h01;
      csat_pkg::CSAT_STROBE:
        if (cnt_r != 7'h00)
          cnt_nxt = cnt_r - 7'h01;
        else if (!lat_r.ext_wait_mask && !CARD_WAIT_N) // [RULE_03] [RULE_04] [RULE_09]
        begin
          extw_nxt = 1'b1;
          st_nxt = csat_pkg::CSAT_EXTW;
        end
        else
        begin
          rd_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          cnt_nxt = {3'h0, lat_r.strobe_addr_hold}; // [RULE_06]
          st_nxt = csat_pkg::CSAT_HOLD;
        end
      csat_pkg::CSAT_EXTW:
        if (!CARD_WAIT_N) // [RULE_09]
          extw_nxt = 1'b1;
        else
        begin
          rd_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          cnt_nxt = {3'h0, lat_r.strobe_addr_hold}; // [RULE_06]
          st_nxt = csat_pkg::CSAT_HOLD;
        end
      csat_pkg::CSAT_HOLD:
        if (cnt_r == 7'h00)
        begin
          oe_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = csat_pkg::CSAT_IDLE;
        end
        else
          cnt_nxt = cnt_r - 7'h01;
      default:
        st_nxt = csat_pkg::CSAT_IDLE;
    endcase
    busy_nxt = (st_nxt != csat_pkg::CSAT_IDLE);
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      st_r <= csat_pkg::CSAT_IDLE;
      cnt_r <= 7'h00;
      lat_r <= '0;
      addr_r <= '0;
      oe_r <= 1'b0;
      rd_n_r <= 1'b1;
      we_n_r <= 1'b1;
      io_r <= 1'b0;
      wr_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      extw_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lat_r <= lat_nxt;
      addr_r <= addr_nxt;
      oe_r <= oe_nxt;
      rd_n_r <= rd_n_nxt;
      we_n_r <= we_n_nxt;
      io_r <= io_nxt;
      wr_r <= wr_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      extw_r <= extw_nxt;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign ACC_BUSY = busy_r;
  assign ACC_DONE = done_r;
  assign CARD_ADDR = addr_r;
  assign CARD_ADDR_OE = oe_r;
  assign CARD_RD_N = rd_n_r;
  assign CARD_WE_N = we_n_r;
  assign CARD_IO_SEL = io_r;

  // ********************************************************************
  // checks
  // ********************************************************************
  logic [7:0] ph_cnt_r;
  logic strb;
  assign strb = !rd_n_r || !we_n_r;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      ph_cnt_r <= 8'h00;
    else if (CLK_EN)
      ph_cnt_r <= (st_nxt != st_r) ? 8'h01 : ph_cnt_r + 8'h01;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST || !CLK_EN);

  sequence s_strobe_end;
    (st_r == csat_pkg::CSAT_STROBE) && (cnt_r == 7'h00);
  endsequence

  property p_wait_len;
    $fell(strb) |-> (st_r == csat_pkg::CSAT_HOLD) && $past(st_r) == csat_pkg::CSAT_STROBE
      ? $past(ph_cnt_r) == {1'b0, csat_pkg::wait_cycles(lat_r.access_wait_count)} : 1'b1;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("strobe length wrong"); // [RULE_01]

  property p_reset_code;
    $past(RST) && !RST |-> cfg_r[csat_pkg::WAIT_LSB +: csat_pkg::FIELD_W]
      == csat_pkg::WAIT_RESET_CODE;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("bad wait reset"); // [RULE_02]

  property p_wait_ignored;
    s_strobe_end and (lat_r.ext_wait_mask == 1'b1) |=> st_r == csat_pkg::CSAT_HOLD && !strb;
  endproperty
  a_wait_ignored: assert property (p_wait_ignored) else $error("masked wait used"); // [RULE_03]

  property p_mask_any_count;
    (st_r == csat_pkg::CSAT_EXTW) |-> !lat_r.ext_wait_mask;
  endproperty
  a_mask_any_count: assert property (p_mask_any_count) else $error("mask not kept"); // [RULE_04]

  property p_reserved_zero;
    S_AXI_RVALID |-> S_AXI_RDATA[5:4] == 2'h0 && S_AXI_RDATA[31:22] == 10'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RULE_05]

  property p_addr_hold;
    $fell(CARD_ADDR_OE) |-> $past(ph_cnt_r) == {4'h0, lat_r.strobe_addr_hold} + 8'h01;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address hold wrong"); // [RULE_06]

  property p_setup;
    $rose(strb) |-> $past(ph_cnt_r) == {4'h0, csat_pkg::delay_code(lat_r.addr_strobe_delay)}
      + 8'h01 && CARD_ADDR_OE;
  endproperty
  a_setup: assert property (p_setup) else $error("strobe delay wrong"); // [RULE_07]

  property p_attr;
    $rose(CARD_ADDR_OE) |-> CARD_IO_SEL == (CARD_ADDR[ADDR_W-1] ? lat_r.upper_half_space_attr
                                                              : lat_r.lower_half_space_attr);
  endproperty
  a_attr: assert property (p_attr) else $error("space attribute wrong"); // [RULE_08]

  sequence s_card_waits;
    s_strobe_end ##0 (!lat_r.ext_wait_mask && !CARD_WAIT_N);
  endsequence

  property p_extend;
    s_card_waits |=> strb && st_r == csat_pkg::CSAT_EXTW && ACC_BUSY;
  endproperty
  a_extend: assert property (p_extend) else $error("wait did not extend strobe"); // [RULE_09]

endmodule // csat_top

// ---- rtl/csat_pkg.sv ----
// package: register map, field layout and timing codes of the card slot access timing block
package csat_pkg;
  // ********************************************************************
  // behaviour
  // ********************************************************************
  // Behaviour
  // [RULE_01] Strobe stays low for 3,6,9,12,15,18,22,26,30,33,36,38,52,60,64,80 cycles per code.
  // [RULE_02] After reset the access wait count field holds 1010.
  // [RULE_03] Mask bit 0 honours the external wait input, mask bit 1 ignores it entirely.
  // [RULE_04] The wait mask setting applies whatever access wait count is programmed.
  // [RULE_05] Bits 5 and 4 of the configuration register always read zero; software writes zero.
  // [RULE_06] After strobe negation the address is held for hold code plus a half cycle; the code holds it for hold code plus one cycle.
  // [RULE_07] Strobe follows the address by delay code plus a half cycle; codes above 7 are barred. The code uses delay code plus one cycle.
  // [RULE_08] Two attribute bits pick memory or I/O access for each half of the area.
  // [RULE_09] With wait honoured, wait is sampled after the wait cycles and extends the strobe.

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam logic [31:0] CFG_RESET = 32'h0000_0500;
  localparam logic [31:0] CFG_WMASK = 32'h0030_7fcf;
  localparam int UPPER_ATTR_BIT = 21;
  localparam int LOWER_ATTR_BIT = 20;
  localparam int DELAY_LSB = 11;
  localparam int WAIT_LSB = 7;
  localparam int MASK_BIT = 6;
  localparam int HOLD_LSB = 0;
  localparam int FIELD_W = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXTW_BIT = 1;
  localparam logic [3:0] WAIT_RESET_CODE = 4'ha;
  localparam logic [3:0] DELAY_MAX = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef struct packed {
    logic upper_half_space_attr;
    logic lower_half_space_attr;
    logic [3:0] addr_strobe_delay;
    logic [3:0] access_wait_count;
    logic ext_wait_mask;
    logic [3:0] strobe_addr_hold;
  } csat_cfg_t;

  typedef enum logic [2:0] {CSAT_IDLE, CSAT_SETUP, CSAT_STROBE, CSAT_EXTW, CSAT_HOLD} csat_state_t;

  // ********************************************************************
  // functions
  // ********************************************************************
  function automatic csat_cfg_t cfg_fields(input logic [31:0] r);
    csat_cfg_t c;
    c.upper_half_space_attr = r[UPPER_ATTR_BIT];
    c.lower_half_space_attr = r[LOWER_ATTR_BIT];
    c.addr_strobe_delay = r[DELAY_LSB +: FIELD_W];
    c.access_wait_count = r[WAIT_LSB +: FIELD_W];
    c.ext_wait_mask = r[MASK_BIT];
    c.strobe_addr_hold = r[HOLD_LSB +: FIELD_W];
    return c;
  endfunction

  function automatic logic [6:0] wait_cycles(input logic [3:0] code);
    logic [6:0] n;
    n = 7'h03;
    unique case (code)
      4'h0: n = 7'h03;
      4'h1: n = 7'h06;
      4'h2: n = 7'h09;
      4'h3: n = 7'h0c;
      4'h4: n = 7'h0f;
      4'h5: n = 7'h12;
      4'h6: n = 7'h16;
      4'h7: n = 7'h1a;
      4'h8: n = 7'h1e;
      4'h9: n = 7'h21;
      4'ha: n = 7'h24;
      4'hb: n = 7'h26;
      4'hc: n = 7'h34;
      4'hd: n = 7'h3c;
      4'he: n = 7'h40;
      4'hf: n = 7'h50;
    endcase
    return n;
  endfunction

  function automatic logic [3:0] delay_code(input logic [3:0] code);
    return (code > DELAY_MAX) ? DELAY_MAX : code;
  endfunction
endpackage

// ---- test/csat_card_model.sv ----
// card model: answers the strobes and drives the wait line
`timescale 1ns/10ps
module csat_card_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // card side
  input wire logic rd_n,
  input wire logic we_n,
  input wire logic [7:0] stretch,
  output logic wait_n
);
  // ********************************************************************
  // strobe cycle counter
  // ********************************************************************
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  always_comb
  begin
    cnt_nxt = (rd_n && we_n) ? 8'h00 : cnt_r + 8'h01;
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end
  // wait low for stretch cycles of each strobe, pulled up otherwise
  assign wait_n = (rd_n && we_n) || (cnt_r >= stretch);
endmodule // csat_card_model

// ---- test/testbench.sv ----
// testbench: register access and card timing checks
`timescale 1ns/10ps
module testbench;
  logic clock, rst, awv, awrdy, wv, wrdy, bv, br, arv, arrdy, rv, rr;
  logic [1:0] bresp, rresp;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, got;
  logic req, wr, busy, done, oe, rd_n, we_n, io, wait_n, io_s, dn;
  logic [25:0] acc_a, card_a, ad_s, aa;
  logic [7:0] stretch;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int d, l, h, o;
  int wt[16] = '{3, 6, 9, 12, 15, 18, 22, 26, 30, 33, 36, 38, 52, 60, 64, 80};

  csat_top dut
  (
    .CLOCK(clock), .RST(rst), .CLK_EN(1'b1),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
    .ACC_REQ(req), .ACC_WRITE(wr), .ACC_ADDR(acc_a), .ACC_BUSY(busy), .ACC_DONE(done),
    .CARD_ADDR(card_a), .CARD_ADDR_OE(oe), .CARD_RD_N(rd_n), .CARD_WE_N(we_n),
    .CARD_IO_SEL(io), .CARD_WAIT_N(wait_n)
  );

  csat_card_model card
  (
    .clock(clock), .rst(rst), .rd_n(rd_n), .we_n(we_n), .stretch(stretch), .wait_n(wait_n)
  );

  // ********************************************************************
  // tasks
  // ********************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clock);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clock);
      awv <= awv && !awrdy;
      wv <= wv && !wrdy;
    end
    while ((awv && !awrdy) || (wv && !wrdy));
    do @(posedge clock); while (!bv);
    br <= 1'b0;
    chk(bresp, er);
  endtask

  task axr(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clock); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clock); while (!rv);
    rr <= 1'b0;
    v = rd;
    chk(rresp, er);
  endtask

  // one card access; counts setup, strobe and hold cycles
  task acc(input logic w, input logic [25:0] a);
    @(posedge clock);
    req <= 1'b1;
    wr <= w;
    acc_a <= a;
    do @(posedge clock); while (!busy);
    req <= 1'b0;
    io_s = io;
    ad_s = card_a;
    d = 0;
    l = 0;
    h = 0;
    o = 0;
    while (busy)
    begin
      if (oe)
        o++;
      if (!(w ? we_n : rd_n))
        l++;
      else if (l == 0)
        d++;
      else
        h++;
      @(posedge clock);
    end
    dn = done && !oe;
  endtask

  // ********************************************************************
  // clock, timeout and tests
  // ********************************************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      final_report;
    end
  end

  initial
  begin
    {awv, wv, br, arv, rr, req, wr} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    acc_a = '0;
    stretch = 8'h00;
    rst = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    axr(12'h000, got, 2'h0);
    chk(got, 32'h0000_0500);
    axw(12'h000, 32'h0030_3fcf, 2'h0);
    axr(12'h000, got, 2'h0);
    chk(got, 32'h0030_3fcf);
    axw(12'h010, 32'h0000_0001, 2'h2);
    axr(12'h010, got, 2'h2);
    chk(got, 32'h0000_0000);
    $display("test registers ended");
    stretch <= 8'h64;
    for (int c = 0; c < 16; c++)
    begin
      axw(12'h000, 32'h0020_0040 | ((c % 8) << 11) | (c << 7) | c, 2'h0);
      aa = {c[0], 25'(c * 37)};
      acc(c[0], aa);
      chk(d, (c % 8) + 1);
      chk(l, wt[c]);
      chk(h, c + 1);
      chk(io_s, c[0]);
      chk(ad_s, aa);
      chk(o, d + l + h);
      chk(dn, 1'b1);
      $display("test timing code %0d ended", c);
    end
    axw(12'h000, 32'h0000_0000, 2'h0);
    stretch <= 8'h0a;
    acc(1'b0, 26'h000_0100);
    chk(l, 11);
    axw(12'h000, 32'h0000_0100, 2'h0);
    stretch <= 8'h05;
    acc(1'b1, 26'h000_0200);
    chk(l, 9);
    $display("test external wait ended");
    final_report;
  end
endmodule // testbench
